/* File: core/watchdog_timed_config_reset_flags.sv */
// watchdog control: timed change sequence, safety levels, reset-cause flags, bus slave
// Summary of operation
// RULE1: level one: plain enable write turns on
// RULE2: unlock write sets change_unlock and enable together
// RULE3: second write within four cycles is accepted
// RULE4: level two: enable always reads one
// RULE5: level two: timeout change needs unlock write
// RULE6: level two: period accepted, enable value ignored
// RULE7: level two: disable sequence keeps watchdog running
// RULE8: bit four set by scan reset
// RULE9: bit three set by watchdog timeout
// RULE10: bit two set by brown-out
// RULE11: bit one set by reset pin
// RULE12: bit zero set by power-on only
// RULE13: software reads then clears flags early
// RULE14: control at 0x60, zero reset, reserved zero
// RULE15: change_unlock clears itself after four cycles
// RULE16: zero enable write ignored unless unlocked
// RULE17: period select changes only inside window
// RULE18: select steps double timeout from 16K
// RULE19: fuse picks level and initial enable
// RULE20: counter restarts on kick, disable, reset
// RULE21: timeout gives one-cycle reset pulse
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timed_config_reset_flags
    import wdog_pkg::*;
#(
    parameter int TIMEOUT_BASE_TICKS = BASE_TICKS
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic safety_level_fuse_i,
    input wire logic wdog_osc_i,
    input wire logic scan_reset_i,
    input wire logic brownout_i,
    input wire logic pin_reset_i,
    input wire logic poweron_i,
    output logic wdog_reset_o,
    output logic wdog_running_o
);
    // ---------------------------------------------------------------
    // pin synchronisers
    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic osc_prev_reg;
    logic osc_tick;
    reset_evt_s evt;

    assign pins = {safety_level_fuse_i, wdog_osc_i, scan_reset_i,
                   brownout_i, pin_reset_i, poweron_i};

    // two flops per pin; left out of reset so the fuse level is sampled during reset
    for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
        always_ff @(posedge core_clk_i) begin
            sync1_reg[i] <= pins[i];
            sync2_reg[i] <= sync1_reg[i];
        end
    end

    assign evt.poweron = sync2_reg[0];
    assign evt.pin = sync2_reg[1];
    assign evt.brownout = sync2_reg[2];
    assign evt.scan = sync2_reg[3];

    // oscillator edge detect on the synchronised copy only; the previous level keeps
    // tracking through reset, so a release while the oscillator is high shows no false tick
    always_ff @(posedge core_clk_i) begin
        osc_prev_reg <= sync2_reg[4];
    end
    assign osc_tick = sync2_reg[4] && !osc_prev_reg;

    // ---------------------------------------------------------------
    // safety level, caught while reset is held
    logic level2_reg;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            level2_reg <= sync2_reg[5]; // [RULE19]
        end
    end

    // ---------------------------------------------------------------
    // chip reset seen by the control register and the counter
    logic wdog_reset_reg;
    logic chip_rst;

    assign chip_rst = rst_i || evt.poweron || evt.pin || evt.brownout || evt.scan
                      || wdog_reset_reg;

    // ---------------------------------------------------------------
    // bus address phase
    logic bus_take;
    reg_sel_e addr_sel;
    bus_phase_s wr_pend_reg;
    logic ctrl_wr;
    logic stat_wr;
    logic kick_wr;

    assign bus_take = hsel_i && htrans_i[HTRANS_ACTIVE_BIT] && hready_i;

    // unmapped addresses decode to none: reads give zero, writes drop
    always_comb begin
        case (haddr_i)
            CTRL_ADDR: addr_sel = SEL_CTRL;
            STAT_ADDR: addr_sel = SEL_STAT;
            KICK_ADDR: addr_sel = SEL_KICK;
            default: addr_sel = SEL_NONE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wr_pend_reg <= '{valid: 1'b0, sel: SEL_NONE};
        end else begin
            wr_pend_reg.valid <= bus_take && hwrite_i;
            wr_pend_reg.sel <= addr_sel;
        end
    end

    assign ctrl_wr = wr_pend_reg.valid && (wr_pend_reg.sel == SEL_CTRL);
    assign stat_wr = wr_pend_reg.valid && (wr_pend_reg.sel == SEL_STAT);
    assign kick_wr = wr_pend_reg.valid && (wr_pend_reg.sel == SEL_KICK);

    // ---------------------------------------------------------------
    // timed change window
    win_state_e win_state_reg;
    logic [2:0] win_cnt_reg;
    logic change_unlock;
    logic unlock_req;
    logic accept;

    assign change_unlock = (win_state_reg == WIN_OPEN);
    // both bits in one write open the window [RULE2] [RULE5]
    assign unlock_req = ctrl_wr && hwdata_i[CU_BIT] && hwdata_i[ON_BIT];
    // second write with unlock cleared while open [RULE3]
    assign accept = ctrl_wr && change_unlock && !hwdata_i[CU_BIT];

    // a fresh unlock write reloads the window; an accepted write closes it
    always_ff @(posedge core_clk_i) begin
        if (chip_rst) begin
            win_state_reg <= WIN_CLOSED;
            win_cnt_reg <= WINDOW_LAST;
        end else if (unlock_req) begin
            win_state_reg <= WIN_OPEN;
            win_cnt_reg <= WINDOW_LOAD;
        end else begin
            case (win_state_reg)
                WIN_OPEN: begin
                    if (accept || win_cnt_reg == WINDOW_LAST) begin
                        win_state_reg <= WIN_CLOSED; // [RULE15]
                    end
                    win_cnt_reg <= win_cnt_reg - 3'h1;
                end
                WIN_CLOSED: begin
                    win_cnt_reg <= WINDOW_LAST;
                end
                default: begin
                    win_state_reg <= WIN_CLOSED;
                    win_cnt_reg <= WINDOW_LAST;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // enable bit
    logic wdog_on_reg;
    logic running;

    // at level two the stored bit is overridden, so a cleared copy never stops it
    always_ff @(posedge core_clk_i) begin
        if (chip_rst) begin
            wdog_on_reg <= CTRL_RESET[ON_BIT]; // [RULE14]
        end else if (unlock_req) begin
            wdog_on_reg <= 1'b1;
        end else if (accept) begin
            wdog_on_reg <= hwdata_i[ON_BIT]; // [RULE3]
        end else if (ctrl_wr && hwdata_i[ON_BIT]) begin
            wdog_on_reg <= 1'b1; // [RULE1]
        end
        // a zero outside the window leaves the bit alone [RULE16]
    end

    assign running = wdog_on_reg || level2_reg; // [RULE4] [RULE6] [RULE7]

    // ---------------------------------------------------------------
    // period select
    logic [SEL_W-1:0] period_sel_reg;

    always_ff @(posedge core_clk_i) begin
        if (chip_rst) begin
            period_sel_reg <= CTRL_RESET[SEL_LSB +: SEL_W];
        end else if (accept) begin
            period_sel_reg <= hwdata_i[SEL_LSB +: SEL_W]; // [RULE17] [RULE6]
        end
    end

    // ---------------------------------------------------------------
    // timeout counter and reset pulse
    logic cnt_expire;
    logic cnt_restart;

    assign cnt_restart = chip_rst || kick_wr || !running; // [RULE20]

    wdog_timeout_counter #(
        .BASE(TIMEOUT_BASE_TICKS),
        .SW(SEL_W)
    ) u_counter (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .tick_i(osc_tick),
        .restart_i(cnt_restart),
        .sel_i(period_sel_reg), // [RULE18]
        .expire_o(cnt_expire)
    );

    // the pulse resets the counter itself, so it never lasts two cycles
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wdog_reset_reg <= 1'b0;
            wdog_running_o <= 1'b0;
        end else begin
            wdog_reset_reg <= cnt_expire && !wdog_reset_reg; // [RULE21]
            wdog_running_o <= running;
        end
    end
    assign wdog_reset_o = wdog_reset_reg;

    // ---------------------------------------------------------------
    // reset-cause flags; sources are levels and a set wins over a clear
    logic [FLAG_W-1:0] flag_reg;
    logic [FLAG_W-1:0] flag_set;
    logic por_clr;

    assign flag_set[POR_BIT] = rst_i || evt.poweron; // [RULE12]
    assign flag_set[PIN_BIT] = evt.pin; // [RULE11]
    assign flag_set[BROWN_BIT] = evt.brownout; // [RULE10]
    assign flag_set[TIMEOUT_BIT] = wdog_reset_reg; // [RULE9]
    assign flag_set[SCAN_BIT] = evt.scan; // [RULE8]
    assign por_clr = rst_i || evt.poweron;

    // software reads, then writes zero to clear [RULE13]
    for (genvar i = 0; i < FLAG_W; i++) begin : g_flag
        always_ff @(posedge core_clk_i) begin
            if (flag_set[i]) begin
                flag_reg[i] <= 1'b1;
            end else if (por_clr && i != POR_BIT) begin
                flag_reg[i] <= 1'b0;
            end else if (stat_wr && !hwdata_i[i]) begin
                flag_reg[i] <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // read data, prepared in the address phase; always ready, always okay
    logic [31:0] rd_word;

    always_comb begin
        rd_word = '0;
        case (addr_sel)
            SEL_CTRL: begin
                rd_word[CU_BIT] = change_unlock;
                rd_word[ON_BIT] = running; // [RULE4]
                rd_word[SEL_LSB +: SEL_W] = period_sel_reg;
                // bits 7:5 stay zero [RULE14]
            end
            SEL_STAT: rd_word[FLAG_W-1:0] = flag_reg;
            SEL_KICK: rd_word = '0;
            default: rd_word = '0;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            hrdata_o <= '0;
            hreadyout_o <= 1'b1;
            hresp_o <= HRESP_OKAY;
        end else begin
            hrdata_o <= (bus_take && !hwrite_i) ? rd_word : 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o <= HRESP_OKAY;
        end
    end

    // ---------------------------------------------------------------
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    logic rd_ctrl;
    assign rd_ctrl = bus_take && !hwrite_i && (addr_sel == SEL_CTRL);

    sequence s_unlock;
        unlock_req && !chip_rst;
    endsequence

    sequence s_quiet4;
        (!ctrl_wr && !chip_rst) [*4];
    endsequence

    plain_enable_a: assert property (ctrl_wr && hwdata_i[ON_BIT] && !chip_rst // [RULE1]
        |=> wdog_on_reg)
        else $error("enable write did not turn the watchdog on");

    window_opens_a: assert property (s_unlock |=> change_unlock) // [RULE2]
        else $error("unlock write did not open the window");

    window_closes_a: assert property (s_unlock ##1 s_quiet4 |=> !change_unlock) // [RULE15]
        else $error("change window stayed open past four cycles");

    window_span_a: assert property (s_unlock ##1 s_quiet4 |-> change_unlock) // [RULE3]
        else $error("change window closed too early");

    level2_reads_a: assert property (rd_ctrl && level2_reg |=> hrdata_o[ON_BIT]) // [RULE4]
        else $error("enable read as zero at level two");

    reserved_zero_a: assert property (rd_ctrl |=> hrdata_o[7:5] == 3'h0) // [RULE14]
        else $error("reserved control bits not zero");

    zero_ignored_a: assert property (ctrl_wr && !change_unlock && !chip_rst // [RULE16]
        |=> $stable(wdog_on_reg) || wdog_on_reg)
        else $error("enable cleared outside the window");

    period_locked_a: assert property (!accept && !chip_rst |=> $stable(period_sel_reg)) // [RULE17]
        else $error("period changed outside the window");

    period_taken_a: assert property (accept && !chip_rst // [RULE6]
        |=> period_sel_reg == $past(hwdata_i[SEL_LSB +: SEL_W]))
        else $error("accepted period not stored");

    level2_runs_a: assert property (level2_reg && accept && !hwdata_i[ON_BIT] // [RULE7]
        |-> ##2 wdog_running_o)
        else $error("watchdog stopped at level two");

    flag_brown_a: assert property (evt.brownout |=> flag_reg[BROWN_BIT]) // [RULE10]
        else $error("brown-out flag not set");

    flag_timeout_a: assert property (wdog_reset_reg |=> flag_reg[TIMEOUT_BIT]) // [RULE9]
        else $error("timeout flag not set");

    por_kept_a: assert property (flag_reg[POR_BIT] && !stat_wr |=> flag_reg[POR_BIT]) // [RULE12]
        else $error("power-on flag lost without a software clear");

    pulse_one_a: assert property (wdog_reset_reg |=> !wdog_reset_reg) // [RULE21]
        else $error("timeout reset pulse longer than one cycle");

    disabled_idle_a: assert property (!running && !level2_reg |=> !cnt_expire) // [RULE20]
        else $error("disabled watchdog expired");

endmodule : watchdog_timed_config_reset_flags
`default_nettype wire

/* File: core/wdog_pkg.sv */
// shared constants, register map and carrier types of the watchdog control block
package wdog_pkg;

    // register byte addresses on the bus
    localparam logic [31:0] CTRL_ADDR = 32'h0000_0060;
    localparam logic [31:0] STAT_ADDR = 32'h0000_0064;
    localparam logic [31:0] KICK_ADDR = 32'h0000_0068;

    // control register fields
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 3;
    localparam int ON_BIT = 3;
    localparam int CU_BIT = 4;
    localparam int CTRL_W = 8;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // reset-cause flag positions
    localparam int POR_BIT = 0;
    localparam int PIN_BIT = 1;
    localparam int BROWN_BIT = 2;
    localparam int TIMEOUT_BIT = 3;
    localparam int SCAN_BIT = 4;
    localparam int FLAG_W = 5;
    localparam logic [4:0] FLAG_RESET = 5'h01;

    // timed change window, in core clock cycles
    localparam int WINDOW_CYCLES = 4;
    localparam logic [2:0] WINDOW_LOAD = 3'(WINDOW_CYCLES - 1);
    localparam logic [2:0] WINDOW_LAST = 3'h0;

    // shortest timeout, in watchdog oscillator cycles
    localparam int BASE_TICKS = 16384;

    // bus encodings
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;

    // number of pin inputs passing the synchroniser
    localparam int SYNC_W = 6;

    typedef enum logic [0:0] {
        WIN_CLOSED = 1'b0,
        WIN_OPEN = 1'b1
    } win_state_e;

    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_CTRL = 2'b01,
        SEL_STAT = 2'b10,
        SEL_KICK = 2'b11
    } reg_sel_e;

    // synchronised reset sources
    typedef struct packed {
        logic scan;
        logic brownout;
        logic pin;
        logic poweron;
    } reset_evt_s;

    // write captured in the address phase
    typedef struct packed {
        logic valid;
        reg_sel_e sel;
    } bus_phase_s;

endpackage : wdog_pkg

/* File: core/wdog_timeout_counter.sv */
// timeout counter stepped by watchdog oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module wdog_timeout_counter
    import wdog_pkg::*;
#(
    parameter int BASE = BASE_TICKS,
    parameter int SW = SEL_W
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic restart_i,
    input wire logic [SW-1:0] sel_i,
    output logic expire_o
);
    localparam int CNT_W = $clog2(BASE) + (1 << SW);

    // the limit shift only works for a power of two base
    if (BASE < 2 || (BASE & (BASE - 1)) != 0) begin : g_bad_base
        $error("wdog_timeout_counter: BASE must be a power of two above one");
    end

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] limit;

    // each select step doubles the timeout
    assign limit = CNT_W'(BASE) << sel_i;

    // restart wins over a tick so a kick never races a timeout
    always_ff @(posedge core_clk_i) begin
        if (rst_i || restart_i) begin
            cnt_reg <= '0;
            expire_o <= 1'b0;
        end else if (tick_i && (cnt_reg >= limit - CNT_W'(1))) begin
            cnt_reg <= '0;
            expire_o <= 1'b1;
        end else begin
            cnt_reg <= tick_i ? cnt_reg + CNT_W'(1) : cnt_reg;
            expire_o <= 1'b0;
        end
    end
endmodule : wdog_timeout_counter
`default_nettype wire

/* File: verification/watchdog_timed_config_reset_flags_tb_top.sv */
// self-checking bench for the watchdog control block over its register bus
`timescale 1ns/1ps
`default_nettype none
module watchdog_timed_config_reset_flags_tb_top
    import wdog_pkg::*;
;
    // short base count keeps the longest timeout near four thousand cycles
    localparam int BASE = 4;
    localparam int OSC_HALF = 4;

    logic core_clk_i;
    logic rst_i;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic fuse;
    logic osc;
    logic scan;
    logic brown;
    logic pin;
    logic por;
    logic wdog_reset;
    logic running;
    int num_errors = 0;
    int n_checks = 0;
    int n_pulses = 0;

    watchdog_timed_config_reset_flags #(.TIMEOUT_BASE_TICKS(BASE)) uut (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .hsel_i(hsel),
        .haddr_i(haddr),
        .htrans_i(htrans),
        .hwrite_i(hwrite),
        .hsize_i(hsize),
        .hwdata_i(hwdata),
        .hready_i(hreadyout),
        .hrdata_o(hrdata),
        .hreadyout_o(hreadyout),
        .hresp_o(hresp),
        .safety_level_fuse_i(fuse),
        .wdog_osc_i(osc),
        .scan_reset_i(scan),
        .brownout_i(brown),
        .pin_reset_i(pin),
        .poweron_i(por),
        .wdog_reset_o(wdog_reset),
        .wdog_running_o(running)
    );

    // core clock, 8 ns period
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    // watchdog oscillator: one tick every eight core cycles, well under the sync limit
    initial begin
        osc = 1'b0;
        forever begin
            repeat (OSC_HALF) @(posedge core_clk_i);
            osc <= ~osc;
        end
    end

    // counts every cycle the timeout pulse is seen
    always @(posedge core_clk_i) begin
        if (wdog_reset === 1'b1) n_pulses <= n_pulses + 1;
    end

    task results;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // single write; entered right after a rising edge, returns on the data-phase edge
    task bus_write(input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= 1'b1;
        htrans <= 2'b10;
        @(posedge core_clk_i);
        while (hreadyout !== 1'b1) @(posedge core_clk_i);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge core_clk_i);
        while (hreadyout !== 1'b1) @(posedge core_clk_i);
    endtask : bus_write

    // single read, data taken at the edge that ends the data phase
    task rd_chk(input logic [31:0] a, input logic [31:0] exp);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= 1'b0;
        htrans <= 2'b10;
        @(posedge core_clk_i);
        while (hreadyout !== 1'b1) @(posedge core_clk_i);
        htrans <= 2'b00;
        @(posedge core_clk_i);
        while (hreadyout !== 1'b1) @(posedge core_clk_i);
        check(hrdata, exp);
        check({31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask : rd_chk

    task set_src(input int k, input logic v);
        case (k)
            0: scan <= v;
            1: brown <= v;
            2: pin <= v;
            default: por <= v;
        endcase
    endtask : set_src

    // waits for the timeout pulse, reports cycles taken
    task wait_pulse(input int lim, output int n);
        n = 0;
        while (wdog_reset !== 1'b1 && n < lim) begin
            @(posedge core_clk_i);
            n++;
        end
    endtask : wait_pulse

    task do_reset;
        rst_i <= 1'b1;
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
    endtask : do_reset

    // cuts a hang short; the tests need roughly five thousand cycles
    initial begin
        #(8 * 30000);
        num_errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        results();
    end

    initial begin
        int n;
        int p;
        int lo;
        int hi;
        logic [31:0] exp;
        logic [2:0] sels [3];
        int pos [4];
        sels = '{3'h0, 3'h1, 3'h7};
        pos = '{SCAN_BIT, BROWN_BIT, PIN_BIT, POR_BIT};
        rst_i = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        fuse = 1'b0;
        scan = 1'b0;
        brown = 1'b0;
        pin = 1'b0;
        por = 1'b0;
        @(posedge core_clk_i);
        do_reset();
        rd_chk(CTRL_ADDR, 32'h00);
        rd_chk(STAT_ADDR, 32'h01);
        rd_chk(32'h0000_0070, 32'h0);
        rd_chk(KICK_ADDR, 32'h0);
        $display("test reset_values done");

        // plain enable, ignored disable, reserved bits, unmapped write, timed change
        bus_write(CTRL_ADDR, 32'he8);
        rd_chk(CTRL_ADDR, 32'h08);
        check({31'h0, running}, 32'h1);
        bus_write(CTRL_ADDR, 32'h05);
        rd_chk(CTRL_ADDR, 32'h08);
        bus_write(32'h0000_006c, 32'h00);
        bus_write(CTRL_ADDR, 32'h18);
        @(posedge core_clk_i);
        bus_write(CTRL_ADDR, 32'h05);
        rd_chk(CTRL_ADDR, 32'h05);
        check({31'h0, running}, 32'h0);
        bus_write(CTRL_ADDR, 32'h0d);
        rd_chk(CTRL_ADDR, 32'h0d);
        bus_write(CTRL_ADDR, 32'h18);
        rd_chk(CTRL_ADDR, 32'h1d);
        repeat (4) @(posedge core_clk_i);
        rd_chk(CTRL_ADDR, 32'h0d);
        bus_write(CTRL_ADDR, 32'h00);
        rd_chk(CTRL_ADDR, 32'h0d);
        $display("test timed_sequence done");

        // timeout length for select steps 0, 1 and 7, pulse width and flag
        for (int i = 0; i < 3; i++) begin
            bus_write(STAT_ADDR, 32'h00);
            bus_write(CTRL_ADDR, 32'h18);
            bus_write(CTRL_ADDR, {28'h0, 1'b1, sels[i]});
            bus_write(KICK_ADDR, 32'h0);
            lo = (BASE << sels[i]) * 2 * OSC_HALF - 8;
            hi = lo + 24;
            wait_pulse(hi + 10, n);
            check({31'h0, n >= lo && n <= hi}, 32'h1);
            @(posedge core_clk_i);
            check({31'h0, wdog_reset}, 32'h0);
            repeat (2) @(posedge core_clk_i);
            rd_chk(STAT_ADDR, 32'h08);
            rd_chk(CTRL_ADDR, 32'h00);
        end
        $display("test timeout_steps done");

        // kicks hold off the reset; a disabled watchdog never fires
        bus_write(CTRL_ADDR, 32'h08);
        p = n_pulses;
        repeat (12) begin
            bus_write(KICK_ADDR, 32'h0);
            repeat (14) @(posedge core_clk_i);
        end
        check(32'(n_pulses - p), 32'h0);
        bus_write(CTRL_ADDR, 32'h18);
        bus_write(CTRL_ADDR, 32'h00);
        rd_chk(CTRL_ADDR, 32'h00);
        repeat (100) @(posedge core_clk_i);
        check(32'(n_pulses - p), 32'h0);
        $display("test kick_disable done");

        // sticky flags per source; ones written to flags do nothing
        bus_write(STAT_ADDR, 32'h00);
        bus_write(STAT_ADDR, 32'h1f);
        rd_chk(STAT_ADDR, 32'h00);
        exp = 32'h0;
        for (int k = 0; k < 4; k++) begin
            bus_write(CTRL_ADDR, 32'h08);
            set_src(k, 1'b1);
            repeat (4) @(posedge core_clk_i);
            set_src(k, 1'b0);
            repeat (6) @(posedge core_clk_i);
            exp = (k == 3) ? 32'h01 : (exp | (32'h1 << pos[k]));
            rd_chk(STAT_ADDR, exp);
            rd_chk(CTRL_ADDR, 32'h00);
        end
        $display("test reset_flags done");

        // higher safety level: always on, timeout still changed by timed sequence
        fuse <= 1'b1;
        do_reset();
        rd_chk(CTRL_ADDR, 32'h08);
        check({31'h0, running}, 32'h1);
        bus_write(CTRL_ADDR, 32'h18);
        bus_write(CTRL_ADDR, 32'h03);
        rd_chk(CTRL_ADDR, 32'h0b);
        check({31'h0, running}, 32'h1);
        bus_write(CTRL_ADDR, 32'h06);
        rd_chk(CTRL_ADDR, 32'h0b);
        bus_write(STAT_ADDR, 32'h00);
        bus_write(KICK_ADDR, 32'h0);
        lo = (BASE << 3) * 2 * OSC_HALF - 8;
        wait_pulse(lo + 34, n);
        check({31'h0, n >= lo && n <= lo + 24}, 32'h1);
        repeat (3) @(posedge core_clk_i);
        rd_chk(STAT_ADDR, 32'h08);
        rd_chk(CTRL_ADDR, 32'h08);
        $display("test safety_level_two done");
        results();
    end
endmodule : watchdog_timed_config_reset_flags_tb_top
`default_nettype wire
